// ### hdl/pad_pkg.sv
// Constants, register offsets and state types of the product align datapath.
// Assumes a 32-bit AXI4-Lite slave with 8-bit byte addresses in front of it.
`default_nettype none

package pad_pkg;

    // ********************************************************
    // Register map (byte addresses, one aligned word each)
    // ********************************************************
    localparam int         PAD_AW       = 8;
    localparam logic [7:0] PAD_OFF_CTL  = 8'h00;
    localparam logic [7:0] PAD_OFF_X    = 8'h04;
    localparam logic [7:0] PAD_OFF_YH   = 8'h08;
    localparam logic [7:0] PAD_OFF_YLO  = 8'h0c;
    localparam logic [7:0] PAD_OFF_P    = 8'h10;
    localparam logic [7:0] PAD_OFF_A0H  = 8'h14;
    localparam logic [7:0] PAD_OFF_A0L  = 8'h18;
    localparam logic [7:0] PAD_OFF_A1H  = 8'h1c;
    localparam logic [7:0] PAD_OFF_A1L  = 8'h20;
    localparam logic [7:0] PAD_OFF_A0G  = 8'h24;
    localparam logic [7:0] PAD_OFF_A1G  = 8'h28;
    localparam logic [7:0] PAD_OFF_CMD  = 8'h2c;
    localparam logic [7:0] PAD_OFF_STAT = 8'h30;

    // ********************************************************
    // Field positions
    // ********************************************************
    localparam int PAD_CTL_W      = 7;
    localparam int PAD_CLR_Y_BIT  = 6;
    localparam int PAD_CLR_A_LSB  = 4;
    localparam int PAD_SAT_LSB    = 2;
    localparam int PAD_ALN_LSB    = 0;
    localparam int PAD_CMD_DST    = 4;

    localparam logic [1:0]  PAD_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  PAD_RESP_SLVERR = 2'h2;
    localparam logic [31:0] PAD_SAT_POS     = 32'h7fffffff;
    localparam logic [31:0] PAD_SAT_NEG     = 32'h80000000;

    typedef enum logic [1:0] {
        PAD_ALN_NONE = 2'h0,
        PAD_ALN_DIV4 = 2'h1,
        PAD_ALN_MUL4 = 2'h2,
        PAD_ALN_RSVD = 2'h3
    } pad_align_t;

    typedef enum logic [3:0] {
        PAD_OP_MUL  = 4'h0,
        PAD_OP_LDP  = 4'h1,
        PAD_OP_ADDP = 4'h2,
        PAD_OP_SUBP = 4'h3,
        PAD_OP_ADDY = 4'h4,
        PAD_OP_SUBY = 4'h5,
        PAD_OP_ANDY = 4'h6,
        PAD_OP_ORY  = 4'h7,
        PAD_OP_XORY = 4'h8,
        PAD_OP_NEG  = 4'h9
    } pad_op_t;

    typedef struct packed {
        logic [PAD_CTL_W-1:0] ctl;
        logic [15:0]          x;
        logic [31:0]          y;
        logic [31:0]          p;
        logic [1:0][35:0]     acc;
        logic                 aw_full;
        logic [PAD_AW-1:0]    aw_addr;
        logic                 w_full;
        logic [31:0]          w_data;
        logic [3:0]           w_strb;
        logic                 bvalid;
        logic [1:0]           bresp;
        logic                 rvalid;
        logic [31:0]          rdata;
        logic [1:0]           rresp;
    } pad_state_t;

    localparam pad_state_t PAD_STATE_RST = '0;

endpackage : pad_pkg

`default_nettype wire

// ### hdl/pad_dp_if.sv
// Interface joining the datapath core to its align and saturation units.
// Assumes purely combinational units on the far side.
`default_nettype none

interface pad_dp_if;
    logic [31:0]      product;
    logic [1:0]       shift_sel;
    logic [35:0]      aligned;
    logic [1:0][35:0] acc;
    logic [1:0]       sat_dis;
    logic [1:0][31:0] bus_val;
    logic [1:0]       ovf;

    modport core  (output product, shift_sel, acc, sat_dis, input aligned, bus_val, ovf);
    modport align (input product, shift_sel, output aligned);
    modport sat   (input acc, sat_dis, output bus_val, ovf);
endinterface : pad_dp_if

`default_nettype wire

// ### hdl/pad_align.sv
// Product to accumulator alignment unit.
// Assumes the product register drives it; only that path is shifted.
`default_nettype none

module pad_align
    import pad_pkg::*;
(
    pad_dp_if.align dp
);

    always_comb begin
        unique case (pad_align_t'(dp.shift_sel))
            PAD_ALN_DIV4: dp.aligned = {{6{dp.product[31]}}, dp.product[31:2]};
            PAD_ALN_MUL4: dp.aligned = {{2{dp.product[31]}}, dp.product, 2'b00};
            PAD_ALN_NONE: dp.aligned = {{4{dp.product[31]}}, dp.product};
            // The reserved code behaves as unshifted so results stay defined.
            default:      dp.aligned = {{4{dp.product[31]}}, dp.product};
        endcase
    end

endmodule : pad_align

`default_nettype wire

// ### hdl/pad_sat.sv
// Saturation of both accumulators on their way to the data bus.
// Assumes the core selects the half it needs from the 32-bit value.
`default_nettype none

module pad_sat
    import pad_pkg::*;
(
    pad_dp_if.sat dp
);

    for (genvar i = 0; i < 2; i++) begin : g_acc
        // Guard bits that differ from bit 31 mean the value no longer fits 32 bits.
        assign dp.ovf[i] = dp.acc[i][35:31] != {5{dp.acc[i][31]}};
        assign dp.bus_val[i] = (dp.ovf[i] && !dp.sat_dis[i])
                             ? (dp.acc[i][35] ? PAD_SAT_NEG : PAD_SAT_POS)
                             : dp.acc[i][31:0];
    end

endmodule : pad_sat

`default_nettype wire

// ### hdl/pad_top.sv
// Multiply and accumulate datapath with its AXI4-Lite register slave.
// Assumes one AXI4-Lite master on aclk; aresetn is synchronous, active low.
`default_nettype none

// Notes on behaviour
// - All arithmetic is two's complement fixed point.
// - Product equals x times upper y half.
// - Y operand is sign-extended to 36 bits.
// - ALU uses full 36-bit accumulators, either destination.
// - Upper-half load clears lower half when enabled.
// - Clear-disable bits: y, second, first accumulator.
// - Saturation-disable bits: second high, first low.
// - Code 00 loads product unshifted, sign extended.
// - Code 10 loads product times four.
// - Code 01 loads product divided by four.
// - Reset leaves the control register unchanged.
// - Only the product path is realigned.
// - Overflowed accumulator reads clamp to 32 bits.
// - Upper-half load sign-extends into guard bits.
module pad_top
    import pad_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [PAD_AW-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [PAD_AW-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready
);

    // ********************************************************
    // State and sub-units
    // ********************************************************
    pad_state_t s_q;
    pad_state_t s_d;
    pad_dp_if   dp ();

    logic                wr_fire;
    logic [31:0]         wr_data;
    logic signed [31:0]  mul_res;
    logic [35:0]         y_ext;
    logic [35:0]         acc_op;
    logic                dst;

    pad_align u_align (.dp(dp.align));
    pad_sat   u_sat   (.dp(dp.sat));

    assign dp.product   = s_q.p;
    assign dp.shift_sel = s_q.ctl[PAD_ALN_LSB+:2];
    assign dp.acc       = s_q.acc;
    assign dp.sat_dis   = s_q.ctl[PAD_SAT_LSB+:2];

    assign mul_res = $signed(s_q.x) * $signed(s_q.y[31:16]);
    assign y_ext   = {{4{s_q.y[31]}}, s_q.y};

    // ********************************************************
    // Register decode
    // ********************************************************
    function automatic logic reg_mapped(input logic [PAD_AW-1:0] a);
        return a inside {PAD_OFF_CTL, PAD_OFF_X, PAD_OFF_YH, PAD_OFF_YLO, PAD_OFF_P,
                         PAD_OFF_A0H, PAD_OFF_A0L, PAD_OFF_A1H, PAD_OFF_A1L,
                         PAD_OFF_A0G, PAD_OFF_A1G, PAD_OFF_CMD, PAD_OFF_STAT};
    endfunction : reg_mapped

    // Accumulator halves always leave through the saturation unit.
    function automatic logic [31:0] reg_read(input logic [PAD_AW-1:0] a);
        logic [31:0] v;
        v = 32'h0;
        unique case (a)
            PAD_OFF_CTL:  v[PAD_CTL_W-1:0] = s_q.ctl;
            PAD_OFF_X:    v[15:0] = s_q.x;
            PAD_OFF_YH:   v[15:0] = s_q.y[31:16];
            PAD_OFF_YLO:  v[15:0] = s_q.y[15:0];
            PAD_OFF_P:    v = s_q.p;
            PAD_OFF_A0H:  v[15:0] = dp.bus_val[0][31:16];
            PAD_OFF_A0L:  v[15:0] = dp.bus_val[0][15:0];
            PAD_OFF_A1H:  v[15:0] = dp.bus_val[1][31:16];
            PAD_OFF_A1L:  v[15:0] = dp.bus_val[1][15:0];
            PAD_OFF_A0G:  v[3:0] = s_q.acc[0][35:32];
            PAD_OFF_A1G:  v[3:0] = s_q.acc[1][35:32];
            PAD_OFF_STAT: v[1:0] = dp.ovf;
            default:      v = 32'h0;
        endcase
        return v;
    endfunction : reg_read

    always_comb begin
        wr_data = reg_read(s_q.aw_addr);
        for (int b = 0; b < 4; b++) begin
            if (s_q.w_strb[b]) begin
                wr_data[8*b+:8] = s_q.w_data[8*b+:8];
            end
        end
    end

    assign wr_fire = s_q.aw_full && s_q.w_full && !s_q.bvalid;
    assign dst     = wr_data[PAD_CMD_DST];
    assign acc_op  = s_q.acc[dst];

    assign awready = !s_q.aw_full && !s_q.bvalid;
    assign wready  = !s_q.w_full && !s_q.bvalid;
    assign arready = !s_q.rvalid;
    assign bvalid  = s_q.bvalid;
    assign bresp   = s_q.bresp;
    assign rvalid  = s_q.rvalid;
    assign rdata   = s_q.rdata;
    assign rresp   = s_q.rresp;

    // ********************************************************
    // Next state
    // ********************************************************
    always_comb begin
        s_d = s_q;
        if (awvalid && awready) begin
            s_d.aw_full = 1'b1;
            s_d.aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            s_d.w_full = 1'b1;
            s_d.w_data = wdata;
            s_d.w_strb = wstrb;
        end
        if (s_q.bvalid && bready) begin
            s_d.bvalid = 1'b0;
        end
        if (s_q.rvalid && rready) begin
            s_d.rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            s_d.rvalid = 1'b1;
            s_d.rdata  = reg_read(araddr);
            s_d.rresp  = reg_mapped(araddr) ? PAD_RESP_OKAY : PAD_RESP_SLVERR;
        end
        if (wr_fire) begin
            s_d.aw_full = 1'b0;
            s_d.w_full  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = reg_mapped(s_q.aw_addr) ? PAD_RESP_OKAY : PAD_RESP_SLVERR;
            unique case (s_q.aw_addr)
                PAD_OFF_CTL: s_d.ctl = wr_data[PAD_CTL_W-1:0];
                PAD_OFF_X:   s_d.x = wr_data[15:0];
                PAD_OFF_YH: begin
                    s_d.y[31:16] = wr_data[15:0];
                    if (!s_q.ctl[PAD_CLR_Y_BIT]) begin
                        s_d.y[15:0] = 16'h0;
                    end
                end
                PAD_OFF_YLO: s_d.y[15:0] = wr_data[15:0];
                PAD_OFF_A0H, PAD_OFF_A1H: begin
                    s_d.acc[s_q.aw_addr == PAD_OFF_A1H][31:16] = wr_data[15:0];
                    s_d.acc[s_q.aw_addr == PAD_OFF_A1H][35:32] = {4{wr_data[15]}};
                    if (!s_q.ctl[PAD_CLR_A_LSB + 32'(s_q.aw_addr == PAD_OFF_A1H)]) begin
                        s_d.acc[s_q.aw_addr == PAD_OFF_A1H][15:0] = 16'h0;
                    end
                end
                PAD_OFF_A0L, PAD_OFF_A1L: begin
                    s_d.acc[s_q.aw_addr == PAD_OFF_A1L][15:0] = wr_data[15:0];
                end
                PAD_OFF_A0G, PAD_OFF_A1G: begin
                    s_d.acc[s_q.aw_addr == PAD_OFF_A1G][35:32] = wr_data[3:0];
                end
                PAD_OFF_CMD: begin
                    // Only the product operand goes through the align unit.
                    unique case (wr_data[3:0])
                        PAD_OP_MUL:  s_d.p = mul_res;
                        PAD_OP_LDP:  s_d.acc[dst] = dp.aligned;
                        PAD_OP_ADDP: s_d.acc[dst] = acc_op + dp.aligned;
                        PAD_OP_SUBP: s_d.acc[dst] = acc_op - dp.aligned;
                        PAD_OP_ADDY: s_d.acc[dst] = acc_op + y_ext;
                        PAD_OP_SUBY: s_d.acc[dst] = acc_op - y_ext;
                        PAD_OP_ANDY: s_d.acc[dst] = acc_op & y_ext;
                        PAD_OP_ORY:  s_d.acc[dst] = acc_op | y_ext;
                        PAD_OP_XORY: s_d.acc[dst] = acc_op ^ y_ext;
                        PAD_OP_NEG:  s_d.acc[dst] = 36'h0 - acc_op;
                        default:     s_d.acc[dst] = acc_op;
                    endcase
                end
                default: s_d.p = s_q.p;
            endcase
        end
        if (!aresetn) begin
            s_d     = PAD_STATE_RST;
            s_d.ctl = s_q.ctl;
        end
    end

    always_ff @(posedge aclk) begin
        s_q <= s_d;
    end

    // ********************************************************
    // Checks
    // ********************************************************
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_yclr_auto: assert property (wr_fire && s_q.aw_addr == PAD_OFF_YH && !s_q.ctl[6]
        |=> s_q.y[15:0] == 16'h0) else $error("y low half not cleared");

    a_ykeep_low: assert property (wr_fire && s_q.aw_addr == PAD_OFF_YH && s_q.ctl[6]
        |=> s_q.y[15:0] == $past(s_q.y[15:0])) else $error("y low half changed");

    a_guard_ext: assert property (wr_fire && s_q.aw_addr == PAD_OFF_A1H
        |=> s_q.acc[1][35:32] == {4{s_q.acc[1][31]}}) else $error("guard bits not extended");

    a_prod_mul: assert property (wr_fire && s_q.aw_addr == PAD_OFF_CMD && wr_data[3:0] == 4'h0
        |=> $signed(s_q.p) == $signed($past(s_q.x)) * $signed($past(s_q.y[31:16])))
        else $error("product mismatch");

    a_ldp_mul4: assert property (wr_fire && s_q.aw_addr == PAD_OFF_CMD && wr_data[4:0] == 5'h01
        && s_q.ctl[1:0] == 2'h2 |=> s_q.acc[0] == {{2{$past(s_q.p[31])}}, $past(s_q.p), 2'b00})
        else $error("times four alignment wrong");

    a_ldp_div4: assert property (wr_fire && s_q.aw_addr == PAD_OFF_CMD && wr_data[4:0] == 5'h11
        && s_q.ctl[1:0] == 2'h1 |=> s_q.acc[1] == {{6{$past(s_q.p[31])}}, $past(s_q.p[31:2])})
        else $error("divide by four alignment wrong");

    a_ldp_plain: assert property (wr_fire && s_q.aw_addr == PAD_OFF_CMD && wr_data[4:0] == 5'h01
        && s_q.ctl[0] == s_q.ctl[1] |=> s_q.acc[0] == {{4{$past(s_q.p[31])}}, $past(s_q.p)})
        else $error("unshifted alignment wrong");

    a_sat_clamp: assert property (arvalid && arready && araddr == PAD_OFF_A0L && dp.ovf[0]
        && !s_q.ctl[2] |=> s_q.rdata == {16'h0, s_q.acc[0][35] ? 16'h0000 : 16'hffff})
        else $error("saturated read wrong");

    // The control word is unwritten before the first bus write, so the compare must treat it as a value.
    a_ctl_reset: assert property (@(posedge aclk) disable iff (1'b0) !aresetn
        |=> s_q.ctl === $past(s_q.ctl)) else $error("control register changed by reset");

    a_bvalid_hold: assert property (s_q.bvalid && !bready |=> s_q.bvalid && $stable(s_q.bresp))
        else $error("write response dropped early");

endmodule : pad_top

`default_nettype wire

// ### testbench/tb_top.sv
// Self-checking bench for the product align datapath behind its AXI4-Lite slave.
// Assumes pad_pkg and the hdl modules are compiled first; the bench is the only bus master.
`default_nettype none

module tb_top
    import pad_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [6:0]  ctl;
        logic [15:0] x;
        logic [15:0] yh;
        pad_op_t     op;
        logic        dst;
        logic [31:0] p;
        logic [35:0] acc;
    } pad_tb_row_t;

    logic              aclk;
    logic              aresetn;
    logic [PAD_AW-1:0] awaddr;
    logic              awvalid;
    logic              awready;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              wvalid;
    logic              wready;
    logic [1:0]        bresp;
    logic              bvalid;
    logic              bready;
    logic [PAD_AW-1:0] araddr;
    logic              arvalid;
    logic              arready;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic              rvalid;
    logic              rready;
    int                err_total;
    int                n_compared;
    pad_tb_row_t       rows [14];
    logic [7:0]        his [3];
    logic [7:0]        los [3];
    int                cb [3];

    pad_top i_dut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
    );

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    // ********************************************************
    // Checking and bus tasks
    // ********************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // The extra edge at the end keeps two transfers from driving one signal in the same step.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] r;
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= 4'hf;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        r = bresp;
        bready <= 1'b0;
        @(posedge aclk);
        chk({30'h0, r}, {30'h0, er});
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge aclk);
        chk(d, ed);
        chk({30'h0, r}, {30'h0, er});
    endtask : rd

    task automatic results();
        $display("compared %0d mismatched %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : results

    initial begin
        repeat (20000) @(posedge aclk);
        err_total++;
        results();
    end

    // ********************************************************
    // Main sequence
    // ********************************************************
    initial begin
        {aresetn, awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
        err_total  = 0;
        n_compared = 0;
        // Each row runs a multiply and then its op on the accumulator left by the row before.
        rows = '{
            '{7'h0c, 16'hfffd, 16'h0007, PAD_OP_LDP,  1'b0, 32'hffffffeb, 36'hfffffffeb},
            '{7'h0d, 16'hfffd, 16'h0007, PAD_OP_LDP,  1'b1, 32'hffffffeb, 36'hffffffffa},
            '{7'h0e, 16'hfffd, 16'h0007, PAD_OP_LDP,  1'b0, 32'hffffffeb, 36'hfffffffac},
            '{7'h0f, 16'hfffd, 16'h0007, PAD_OP_LDP,  1'b0, 32'hffffffeb, 36'hfffffffeb},
            '{7'h0e, 16'h7fff, 16'h7fff, PAD_OP_LDP,  1'b0, 32'h3fff0001, 36'h0fffc0004},
            '{7'h0c, 16'h7fff, 16'h7fff, PAD_OP_ADDP, 1'b0, 32'h3fff0001, 36'h13ffb0005},
            '{7'h0c, 16'h7fff, 16'h7fff, PAD_OP_SUBY, 1'b0, 32'h3fff0001, 36'h0bffc0005},
            '{7'h0c, 16'h7fff, 16'h8000, PAD_OP_ADDY, 1'b0, 32'hc0008000, 36'h03ffc0005},
            '{7'h0c, 16'h7fff, 16'h8000, PAD_OP_NEG,  1'b0, 32'hc0008000, 36'hfc003fffb},
            '{7'h0c, 16'h7fff, 16'hffff, PAD_OP_ANDY, 1'b0, 32'hffff8001, 36'hfc0030000},
            '{7'h0c, 16'h7fff, 16'h0004, PAD_OP_ORY,  1'b0, 32'h0001fffc, 36'hfc0070000},
            '{7'h0c, 16'h7fff, 16'h0001, PAD_OP_XORY, 1'b0, 32'h00007fff, 36'hfc0060000},
            '{7'h0c, 16'h7fff, 16'h0001, PAD_OP_SUBP, 1'b0, 32'h00007fff, 36'hfc0058001},
            '{7'h0c, 16'hfffd, 16'h0007, PAD_OP_LDP,  1'b1, 32'hffffffeb, 36'hfffffffeb}};
        his = '{PAD_OFF_YH, PAD_OFF_A0H, PAD_OFF_A1H};
        los = '{PAD_OFF_YLO, PAD_OFF_A0L, PAD_OFF_A1L};
        cb  = '{6, 4, 5};
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        foreach (rows[i]) begin
            wr(PAD_OFF_CTL, {25'h0, rows[i].ctl}, PAD_RESP_OKAY);
            wr(PAD_OFF_X, {16'h0, rows[i].x}, PAD_RESP_OKAY);
            wr(PAD_OFF_YH, {16'h0, rows[i].yh}, PAD_RESP_OKAY);
            wr(PAD_OFF_CMD, {27'h0, 1'b0, PAD_OP_MUL}, PAD_RESP_OKAY);
            wr(PAD_OFF_CMD, {27'h0, rows[i].dst, rows[i].op}, PAD_RESP_OKAY);
            rd(PAD_OFF_P, rows[i].p, PAD_RESP_OKAY);
            rd(rows[i].dst ? PAD_OFF_A1G : PAD_OFF_A0G, {28'h0, rows[i].acc[35:32]}, PAD_RESP_OKAY);
            rd(rows[i].dst ? PAD_OFF_A1H : PAD_OFF_A0H, {16'h0, rows[i].acc[31:16]}, PAD_RESP_OKAY);
            rd(rows[i].dst ? PAD_OFF_A1L : PAD_OFF_A0L, {16'h0, rows[i].acc[15:0]}, PAD_RESP_OKAY);
        end
        wr(PAD_OFF_CTL, 32'h02, PAD_RESP_OKAY);
        wr(PAD_OFF_X, 32'h7fff, PAD_RESP_OKAY);
        wr(PAD_OFF_YH, 32'h7fff, PAD_RESP_OKAY);
        wr(PAD_OFF_CMD, {27'h0, 1'b0, PAD_OP_MUL}, PAD_RESP_OKAY);
        wr(PAD_OFF_CMD, {27'h0, 1'b0, PAD_OP_LDP}, PAD_RESP_OKAY);
        rd(PAD_OFF_A0H, 32'h7fff, PAD_RESP_OKAY);
        rd(PAD_OFF_A0L, 32'hffff, PAD_RESP_OKAY);
        wr(PAD_OFF_CMD, {27'h0, 1'b0, PAD_OP_NEG}, PAD_RESP_OKAY);
        rd(PAD_OFF_A0H, 32'h8000, PAD_RESP_OKAY);
        rd(PAD_OFF_A0L, 32'h0000, PAD_RESP_OKAY);
        rd(PAD_OFF_A1L, 32'hffeb, PAD_RESP_OKAY);
        wr(PAD_OFF_CTL, 32'h06, PAD_RESP_OKAY);
        rd(PAD_OFF_A0H, 32'h0003, PAD_RESP_OKAY);
        rd(PAD_OFF_A0L, 32'hfffc, PAD_RESP_OKAY);
        wr(PAD_OFF_CTL, 32'h0a, PAD_RESP_OKAY);
        rd(PAD_OFF_A0H, 32'h8000, PAD_RESP_OKAY);
        // Align code 10 stays selected here, so a shifted bus write would show up at once.
        for (int i = 0; i < 3; i++) begin
            wr(PAD_OFF_CTL, 32'h0e | (32'h1 << cb[i]), PAD_RESP_OKAY);
            wr(los[i], 32'h1234, PAD_RESP_OKAY);
            wr(his[i], 32'h8000, PAD_RESP_OKAY);
            rd(los[i], 32'h1234, PAD_RESP_OKAY);
            wr(PAD_OFF_CTL, 32'h0e, PAD_RESP_OKAY);
            wr(los[i], 32'h1234, PAD_RESP_OKAY);
            wr(his[i], 32'h8000, PAD_RESP_OKAY);
            rd(los[i], 32'h0000, PAD_RESP_OKAY);
            rd(his[i], 32'h8000, PAD_RESP_OKAY);
        end
        rd(PAD_OFF_A0G, 32'hf, PAD_RESP_OKAY);
        rd(PAD_OFF_A1G, 32'hf, PAD_RESP_OKAY);
        wr(8'hfc, 32'h1, PAD_RESP_SLVERR);
        rd(8'hfc, 32'h0, PAD_RESP_SLVERR);
        wr(PAD_OFF_P, 32'h5555, PAD_RESP_OKAY);
        rd(PAD_OFF_P, 32'h3fff0001, PAD_RESP_OKAY);
        wr(PAD_OFF_CTL, 32'h5a, PAD_RESP_OKAY);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(PAD_OFF_CTL, 32'h5a, PAD_RESP_OKAY);
        rd(PAD_OFF_P, 32'h0, PAD_RESP_OKAY);
        results();
    end
endmodule : tb_top

`default_nettype wire
